/* inc/rpic_pkg.sv */
package rpic_pkg;
  localparam logic [3:0] ADDR_SEC = 4'h0;
  localparam logic [3:0] ADDR_ADJ = 4'h7;
  localparam logic [3:0] ADDR_CTRL1 = 4'hE;
  localparam logic [3:0] ADDR_CTRL2 = 4'hF;
  // Control one fields
  localparam int CT_LSB = 0;
  localparam int TEST_BIT = 3;
  localparam int CHG_BIT = 4;
  localparam int DALE_BIT = 6;
  localparam int WALE_BIT = 7;
  // Control/status two fields; DEV_BIT is bit 7 of the adjustment register
  localparam int DAILY_ALARM_FLAG_BIT = 0;
  localparam int WEEKLY_ALARM_FLAG_BIT = 1;
  localparam int PERIODIC_FLAG_BIT = 2;
  localparam int SCR2_BIT = 3;
  localparam int PON_BIT = 4;
  localparam int OSC_HALT_FLAG_BIT = 5;
  localparam int SUPPLY_LOW_FLAG_BIT = 6;
  localparam int SCR1_BIT = 7;
  localparam int DEV_BIT = 7;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h70;
  localparam logic [7:0] ADJ_RST = 8'h00;
  // Keeps flags that survive a power-on clear
  localparam logic [7:0] CTRL2_PON_KEEP = 8'h70;
  localparam logic [15:0] DIV_NOM_TERM = 16'h7FFF;
  localparam logic [5:0] ADJ_PERIOD_DEV0 = 6'h13;
  localparam logic [5:0] ADJ_PERIOD_DEV1 = 6'h3B;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SEC_INC_DELAY_NS = 46000;
  localparam int SEC_INC_DELAY_CYC = (SEC_INC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {RPIC_OFF, RPIC_LOW, RPIC_PULSE, RPIC_LEVEL} rpic_mode_t;
endpackage

/* rtl/rpic_subsec_div.sv */
`timescale 1ns/1ns
`default_nettype none
module rpic_subsec_div #(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic [DIV_W-1:0] term_in,
  output logic [DIV_W-1:0] count_out,
  output logic wrap_out
);
  import rpic_pkg::*;

  logic [DIV_W-1:0] next_count;
  logic next_wrap;

  if (DIV_W < 16) begin : g_width_chk
    $error("divider too narrow");
  end

  always_comb begin
    next_count = count_out;
    next_wrap = 1'b0;
    if (clear_in) begin
      next_count = '0;
    end else if (tick_in) begin
      if (count_out >= term_in) begin
        next_count = '0;
        next_wrap = 1'b1;
      end else begin
        next_count = count_out + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      count_out <= '0;
      wrap_out <= 1'b0;
    end else begin
      count_out <= next_count;
      wrap_out <= next_wrap;
    end
  end
endmodule
`default_nettype wire

/* rtl/rpic_ctrl.sv */
// What this block does
// - Charge-path control 0 keeps the charge switch closed always.
// - Control 1: charge switch opens above rising, closes below falling threshold.
// - Power-on flag set clears charge-path control, closing the charge switch.
// - Main switch opens below falling threshold, closes above rising one.
// - With control 1 both switches change in the same cycle.
// - Selects 010/011 give 2 Hz/1 Hz half-duty waves tied to seconds.
// - Level selects fire each second, minute, hour or month boundary.
// - Pulse mode: second increments about 46 us after the falling edge.
// - Pulse mode: second write clears divider and drives interrupt low.
// - Level mode interrupt falls one cycle after the second increment.
// - Adjustment stretches or shrinks one second every 20 or 60 s.
// - Control two layout and default 70h.
// - Scratch one is a plain read/write bit.
// - Scratch one clears when the power-on flag sets.
// - Level mode: writing 0 to periodic flag releases interrupt; 1 ignored.
// - Power-on clears adjustment and both controls except three flags.
// - Control one: select in 2..0, test bit 3, charge control bit 4.
`timescale 1ns/1ns
`default_nettype none
module rpic_ctrl #(
  parameter int SEC_INC_DELAY = rpic_pkg::SEC_INC_DELAY_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic osc_tick_in,
  input wire logic por_in,
  input wire logic vcc_above_rise_in,
  input wire logic vcc_below_fall_in,
  input wire logic osc_halt_in,
  input wire logic supply_low_in,
  input wire logic min_boundary_in,
  input wire logic hour_boundary_in,
  input wire logic month_boundary_in,
  input wire logic alarm_w_match_in,
  input wire logic alarm_d_match_in,
  output logic interrupt_out_n,
  output logic charge_path_switch_out,
  output logic main_supply_switch_out,
  output logic sec_inc_out,
  output logic test_mode_out
);
  import rpic_pkg::*;

  localparam int DW = $clog2(SEC_INC_DELAY + 1);

  if (SEC_INC_DELAY < 2) begin : g_delay_chk
    $error("second delay must be at least 2 cycles");
  end

  function automatic rpic_mode_t mode_of(input logic [2:0] sel);
    if (sel[2]) return RPIC_LEVEL;
    if (sel[1]) return RPIC_PULSE;
    if (sel[0]) return RPIC_LOW;
    return RPIC_OFF;
  endfunction

  // Pin synchronisers: pins are osc tick, por, above, below, halt, low
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic [1:0] sync_c;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= {supply_low_in, osc_halt_in, vcc_below_fall_in, vcc_above_rise_in,
                 por_in, osc_tick_in};
      sync_b <= sync_a;
      sync_c <= sync_b[1:0];
    end
  end

  logic tick;
  logic pon_event;
  assign tick = sync_b[0] & ~sync_c[0];
  assign pon_event = sync_b[1] & ~sync_c[1];

  // Register group
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic [7:0] adj;
  logic [7:0] next_ctrl_one;
  logic [7:0] next_ctrl_two;
  logic [7:0] next_adj;
  logic [7:0] next_rdata;
  logic wr_sec;
  logic wr_c2;
  logic level_event;
  logic pulse_low;
  rpic_mode_t mode;

  assign mode = mode_of(ctrl_one[CT_LSB +: 3]);
  assign wr_sec = reg_wr_in && (reg_addr_in == ADDR_SEC);
  assign wr_c2 = reg_wr_in && (reg_addr_in == ADDR_CTRL2);

  always_comb begin
    next_ctrl_one = ctrl_one;
    next_ctrl_two = ctrl_two;
    next_adj = adj;
    next_rdata = reg_rdata_out;
    if (reg_wr_in && reg_addr_in == ADDR_CTRL1) begin
      next_ctrl_one = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == ADDR_ADJ) begin
      next_adj = reg_wdata_in;
    end
    if (wr_c2) begin
      next_ctrl_two[SCR1_BIT] = reg_wdata_in[SCR1_BIT];
      next_ctrl_two[SCR2_BIT] = reg_wdata_in[SCR2_BIT];
      // Sticky flags take only a written 0
      next_ctrl_two[SUPPLY_LOW_FLAG_BIT] = ctrl_two[SUPPLY_LOW_FLAG_BIT] & reg_wdata_in[SUPPLY_LOW_FLAG_BIT];
      next_ctrl_two[OSC_HALT_FLAG_BIT] = ctrl_two[OSC_HALT_FLAG_BIT] & reg_wdata_in[OSC_HALT_FLAG_BIT];
      next_ctrl_two[PON_BIT] = ctrl_two[PON_BIT] & reg_wdata_in[PON_BIT];
      next_ctrl_two[WEEKLY_ALARM_FLAG_BIT] = ctrl_two[WEEKLY_ALARM_FLAG_BIT] & reg_wdata_in[WEEKLY_ALARM_FLAG_BIT];
      next_ctrl_two[DAILY_ALARM_FLAG_BIT] = ctrl_two[DAILY_ALARM_FLAG_BIT] & reg_wdata_in[DAILY_ALARM_FLAG_BIT];
      if (mode == RPIC_LEVEL) begin
        next_ctrl_two[PERIODIC_FLAG_BIT] = ctrl_two[PERIODIC_FLAG_BIT] & reg_wdata_in[PERIODIC_FLAG_BIT];
      end
    end
    // Hardware sets win over a same-cycle clear
    if (sync_b[5]) next_ctrl_two[SUPPLY_LOW_FLAG_BIT] = 1'b1;
    if (sync_b[4]) next_ctrl_two[OSC_HALT_FLAG_BIT] = 1'b1;
    if (alarm_w_match_in && ctrl_one[WALE_BIT]) next_ctrl_two[WEEKLY_ALARM_FLAG_BIT] = 1'b1;
    if (alarm_d_match_in && ctrl_one[DALE_BIT]) next_ctrl_two[DAILY_ALARM_FLAG_BIT] = 1'b1;
    if (!ctrl_one[WALE_BIT]) next_ctrl_two[WEEKLY_ALARM_FLAG_BIT] = 1'b0;
    if (!ctrl_one[DALE_BIT]) next_ctrl_two[DAILY_ALARM_FLAG_BIT] = 1'b0;
    unique case (mode)
      RPIC_OFF: next_ctrl_two[PERIODIC_FLAG_BIT] = 1'b0;
      RPIC_LOW: next_ctrl_two[PERIODIC_FLAG_BIT] = 1'b1;
      RPIC_PULSE: next_ctrl_two[PERIODIC_FLAG_BIT] = pulse_low;
      RPIC_LEVEL: begin
        if (level_event) next_ctrl_two[PERIODIC_FLAG_BIT] = 1'b1;
      end
    endcase
    if (pon_event) begin
      next_ctrl_one = CTRL1_RST;
      next_adj = ADJ_RST;
      next_ctrl_two = (next_ctrl_two & CTRL2_PON_KEEP) | 8'(1 << PON_BIT);
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_ADJ: next_rdata = adj;
        ADDR_CTRL1: next_rdata = ctrl_one;
        ADDR_CTRL2: next_rdata = ctrl_two;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ctrl_one <= CTRL1_RST;
      ctrl_two <= CTRL2_RST;
      adj <= ADJ_RST;
      reg_rdata_out <= 8'h00;
    end else begin
      ctrl_one <= next_ctrl_one;
      ctrl_two <= next_ctrl_two;
      adj <= next_adj;
      reg_rdata_out <= next_rdata;
    end
  end

  // Timing group
  logic [15:0] div_count;
  logic div_wrap;
  logic [15:0] term;
  logic [5:0] adj_sec;
  logic [5:0] next_adj_sec;
  logic [DW-1:0] delay;
  logic [DW-1:0] next_delay;
  logic next_sec_inc;
  logic next_interrupt_out_n_n;
  logic alarm_low;

  rpic_subsec_div #(.DIV_W(16)) u_div (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick),
    .clear_in(wr_sec),
    .term_in(term),
    .count_out(div_count),
    .wrap_out(div_wrap)
  );

  // One adjusted second per period; magnitude stays under 64 ticks
  always_comb begin
    term = DIV_NOM_TERM;
    if (adj_sec == 6'h00 && adj[6:0] != 7'h00) begin
      term = adj[6] ? DIV_NOM_TERM - {10'h000, adj[5:0]}
                    : DIV_NOM_TERM + {10'h000, adj[5:0]};
    end
  end

  // Low in the first half of each period, so a divider clear drives low
  assign pulse_low = ctrl_one[CT_LSB] ? (div_count[15:14] == 2'b00)
                                      : !div_count[13];
  assign level_event = sec_inc_out && (!ctrl_one[CT_LSB + 1] && !ctrl_one[CT_LSB] ||
    (ctrl_one[CT_LSB +: 2] == 2'b01 && min_boundary_in) ||
    (ctrl_one[CT_LSB +: 2] == 2'b10 && hour_boundary_in) ||
    (ctrl_one[CT_LSB +: 2] == 2'b11 && month_boundary_in));
  assign alarm_low = ctrl_two[WEEKLY_ALARM_FLAG_BIT] | ctrl_two[DAILY_ALARM_FLAG_BIT];

  always_comb begin
    next_adj_sec = adj_sec;
    if (div_wrap) begin
      if (adj_sec >= (adj[DEV_BIT] ? ADJ_PERIOD_DEV1 : ADJ_PERIOD_DEV0)) begin
        next_adj_sec = 6'h00;
      end else begin
        next_adj_sec = adj_sec + 6'h01;
      end
    end
    next_delay = delay;
    next_sec_inc = 1'b0;
    if (wr_sec) begin
      next_delay = '0;
    end else if (div_wrap) begin
      next_delay = DW'(SEC_INC_DELAY);
    end else if (delay != '0) begin
      next_delay = delay - 1'b1;
      next_sec_inc = (delay == DW'(1));
    end
    unique case (mode)
      RPIC_OFF: next_interrupt_out_n_n = 1'b1;
      RPIC_LOW: next_interrupt_out_n_n = 1'b0;
      RPIC_PULSE: next_interrupt_out_n_n = !pulse_low;
      RPIC_LEVEL: next_interrupt_out_n_n = !next_ctrl_two[PERIODIC_FLAG_BIT];
    endcase
    if (alarm_low) next_interrupt_out_n_n = 1'b0;
  end

  // With charge control 1, charge path takes the inverse of main switch in the same cycle
  logic next_main;
  logic next_charge;
  always_comb begin
    next_main = main_supply_switch_out;
    if (sync_b[3]) next_main = 1'b0;
    else if (sync_b[2]) next_main = 1'b1;
    next_charge = !ctrl_one[CHG_BIT] || !next_main;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      adj_sec <= 6'h00;
      delay <= '0;
      sec_inc_out <= 1'b0;
      interrupt_out_n <= 1'b1;
      main_supply_switch_out <= 1'b1;
      charge_path_switch_out <= 1'b1;
      test_mode_out <= 1'b0;
    end else begin
      adj_sec <= next_adj_sec;
      delay <= next_delay;
      sec_inc_out <= next_sec_inc;
      interrupt_out_n <= next_interrupt_out_n_n;
      main_supply_switch_out <= next_main;
      charge_path_switch_out <= next_charge;
      test_mode_out <= next_ctrl_one[TEST_BIT];
    end
  end

  // Checks
  sequence s_sec_write;
    wr_sec && mode == RPIC_PULSE && !alarm_low;
  endsequence
  sequence s_low_two;
    1'b1 ##1 !interrupt_out_n;
  endsequence

  a_charge_closed_ctrl0: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !ctrl_one[CHG_BIT] |=> charge_path_switch_out) else $error("charge switch opened");
  a_switch_pair_move: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ctrl_one[CHG_BIT] && !pon_event |=> charge_path_switch_out == !main_supply_switch_out)
    else $error("switches not complementary");
  a_main_opens_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    sync_b[3] |=> !main_supply_switch_out) else $error("main switch not open");
  a_pon_clears_ctrl: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pon_event |=> ctrl_one == 8'h00 && !ctrl_two[SCR1_BIT] && ctrl_two[PON_BIT])
    else $error("power-on clear missing");
  a_fixed_low_mode: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    mode == RPIC_LOW && !pon_event |=> !interrupt_out_n) else $error("not held low");
  a_sec_write_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_sec_write ##1 (mode == RPIC_PULSE && !alarm_low) |-> s_low_two)
    else $error("second write did not drive low");
  a_flag_write_one: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    mode == RPIC_LEVEL && !ctrl_two[PERIODIC_FLAG_BIT] && !level_event && !pon_event &&
    $stable(ctrl_one) |=> !ctrl_two[PERIODIC_FLAG_BIT]) else $error("flag set without event");
  a_sec_inc_delay: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    sec_inc_out |-> $past(delay) == DW'(1)) else $error("second increment mistimed");
  a_reset_defaults: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> ctrl_two == 8'h70) else $error("control two default wrong");
endmodule
`default_nettype wire

/* verification/rpic_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rpic_host_model (
  input wire logic ref_clk_in,
  output logic [3:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 4'h0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // Everything moves 1 ns after an edge and holds across the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_wr_out = 1'b0;
    // Released data lines must not keep looking valid
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_rd_out = 1'b0;
    @(posedge ref_clk_in);
    #1;
    d = reg_rdata_in;
  endtask
  // Normal use: charge path on, factory test off
  task automatic restore();
    wr(rpic_pkg::ADDR_CTRL1, 8'h00);
  endtask
endmodule
`default_nettype wire

/* verification/test_rtc_periodic_interrupt_control.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_rtc_periodic_interrupt_control;
  import rpic_pkg::*;
  logic ref_clk_in, rst_n_in, osc, osc_run, por, above, below, halt, low, alarm_d;
  logic [3:0] addr;
  logic wr, rd, irq_n, chg, mains, sec_inc, test;
  logic [7:0] wdata, rdata, d;
  int bad_count = 0;
  int compares = 0;
  int ticks, n;
  time t0;

  rpic_ctrl #(.SEC_INC_DELAY(40)) dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .osc_tick_in(osc), .por_in(por), .vcc_above_rise_in(above),
    .vcc_below_fall_in(below), .osc_halt_in(halt), .supply_low_in(low),
    .min_boundary_in(1'b0), .hour_boundary_in(1'b0), .month_boundary_in(1'b0),
    .alarm_w_match_in(1'b0), .alarm_d_match_in(alarm_d), .interrupt_out_n(irq_n),
    .charge_path_switch_out(chg), .main_supply_switch_out(mains),
    .sec_inc_out(sec_inc), .test_mode_out(test));
  rpic_host_model host_u (.ref_clk_in(ref_clk_in), .reg_addr_out(addr),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata));

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // Oscillator runs at half the clock so every period survives the synchroniser
  always @(posedge ref_clk_in) begin
    #1;
    if (osc_run) osc = ~osc;
  end
  always @(posedge osc) ticks++;

  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic complete_run();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic expire(input int k, input int lim);
    if (k >= lim) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic wait_irq(input logic v, input int lim);
    int k;
    for (k = 0; k < lim && irq_n !== v; k++) settle(1);
    expire(k, lim);
  endtask

  initial begin
    rst_n_in = 1'b0;
    {osc, osc_run, por, below, halt, low, alarm_d} = 7'h00;
    above = 1'b1;
    ticks = 0;
    settle(2);
    rst_n_in = 1'b1;
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h70)
    host_u.rd(ADDR_CTRL1, d); `CHK(d, 8'h00)
    `CHK(irq_n, 1'b1)
    host_u.wr(ADDR_CTRL1, 8'h01);
    settle(2); `CHK(irq_n, 1'b0)
    host_u.wr(ADDR_CTRL1, 8'h00);
    settle(2); `CHK(irq_n, 1'b1)
    host_u.wr(ADDR_CTRL2, 8'h80);
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h80)
    host_u.wr(ADDR_CTRL2, 8'h00);
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h00)
    // Alarm flag sits in bit 0 and pulls the interrupt low
    host_u.wr(ADDR_CTRL1, 8'h40);
    alarm_d = 1'b1;
    settle(1);
    alarm_d = 1'b0;
    host_u.rd(ADDR_CTRL2, d); `CHK({d, irq_n}, 9'h002)
    host_u.restore();
    host_u.rd(ADDR_CTRL2, d); `CHK({d, irq_n}, 9'h001)
    // One pin at a time, so a swapped flag shows
    halt = 1'b1;
    settle(4);
    halt = 1'b0;
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h20)
    low = 1'b1;
    settle(4);
    low = 1'b0;
    settle(4);
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h60)
    host_u.wr(ADDR_CTRL2, 8'hE0);
    {above, below} = 2'b01;
    settle(6); `CHK({mains, chg}, 2'b01)
    {above, below} = 2'b10;
    settle(6); `CHK({mains, chg}, 2'b11)
    host_u.wr(ADDR_CTRL1, 8'h18);
    settle(2); `CHK({chg, test}, 2'b01)
    {above, below} = 2'b01;
    for (n = 0; n < 10 && mains !== 1'b0; n++) settle(1);
    expire(n, 10); `CHK(chg, 1'b1)
    {above, below} = 2'b10;
    for (n = 0; n < 10 && mains !== 1'b1; n++) settle(1);
    expire(n, 10); `CHK(chg, 1'b0)
    host_u.wr(ADDR_ADJ, 8'h85);
    por = 1'b1;
    settle(8);
    por = 1'b0;
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h70)
    host_u.rd(ADDR_CTRL1, d); `CHK(d, 8'h00)
    host_u.rd(ADDR_ADJ, d); `CHK(d, 8'h00)
    `CHK({chg, test, irq_n}, 3'b101)
    host_u.restore();
    host_u.wr(ADDR_CTRL2, 8'h00);
    // First second shortened by 16 ticks; half-second points unaffected
    host_u.wr(ADDR_ADJ, 8'h50);
    // Quarter-second steps of the divider from a freshly cleared start
    osc_run = 1'b1;
    host_u.wr(ADDR_CTRL1, 8'h02);
    host_u.wr(ADDR_SEC, 8'h00);
    ticks = 0;
    settle(2); `CHK(irq_n, 1'b0)
    wait_irq(1'b1, 20000);
    `CHK(ticks >= 8188 && ticks <= 8196, 1'b1)
    wait_irq(1'b0, 20000);
    `CHK(ticks >= 16380 && ticks <= 16392, 1'b1)
    host_u.wr(ADDR_CTRL1, 8'h03);
    settle(2); `CHK(irq_n, 1'b1)
    wait_irq(1'b0, 70000);
    t0 = $time;
    `CHK(ticks >= 32748 && ticks <= 32756, 1'b1)
    // Increment lags the falling edge; switch to level mode inside that gap
    host_u.wr(ADDR_CTRL1, 8'h04);
    host_u.wr(ADDR_CTRL2, 8'h00);
    settle(1); `CHK(irq_n, 1'b1)
    for (n = 0; n < 200 && sec_inc !== 1'b1; n++) settle(1);
    expire(n, 200);
    `CHK(($time - t0) / 4 >= 36 && ($time - t0) / 4 <= 44, 1'b1)
    `CHK(irq_n, 1'b1)
    settle(1); `CHK(irq_n, 1'b0)
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h04)
    host_u.wr(ADDR_CTRL2, 8'h00);
    settle(1); `CHK(irq_n, 1'b1)
    host_u.wr(ADDR_CTRL2, 8'h04);
    host_u.rd(ADDR_CTRL2, d); `CHK(d, 8'h00)
    `CHK(irq_n, 1'b1)
    complete_run();
  end
endmodule
`default_nettype wire
